/* File: ccs_master.sv */
module ccs_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
    } ccs_fifo_regs_t;

    ccs_fifo_regs_t f_r;
    ccs_fifo_regs_t f_nxt;
    logic           push;
    logic           pop;

    assign in_ready = (f_r.cnt != (AW + 1)'(DEPTH));
    assign out_valid = (f_r.cnt != '0);
    assign out_data = f_r.mem[f_r.rp];

    always_comb begin
        f_nxt = f_r;
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        if (push) begin
            f_nxt.mem[f_r.wp] = in_data;
            f_nxt.wp = f_r.wp + 1'b1;
        end
        if (pop) begin
            f_nxt.rp = f_r.rp + 1'b1;
        end
        if (push && !pop) begin
            f_nxt.cnt = f_r.cnt + 1'b1;
        end else if (pop && !push) begin
            f_nxt.cnt = f_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            f_r <= '0;
        end else if (ce) begin
            f_r <= f_nxt;
        end
    end
endmodule

module ccs_master
    import ccs_pkg::*;
#(
    parameter int HOLD_CYC = HOLD_MAX_MS * CLK_MHZ * 1000
) (
    input  wire logic       REF_CLK,
    input  wire logic       RST,
    input  wire logic       CE,
    ccs_if.host             BUS,
    input  wire logic       CMD_VALID,
    output logic            CMD_READY,
    input  wire logic       CMD_RW,
    input  wire logic       CMD_SEL,
    input  wire logic       CMD_PTR_EN,
    input  wire logic [7:0] CMD_PTR,
    input  wire logic [7:0] CMD_LEN,
    input  wire logic       WR_VALID,
    output logic            WR_READY,
    input  wire logic [7:0] WR_DATA,
    output logic            RD_VALID,
    output logic [7:0]      RD_DATA,
    output logic            DONE,
    output logic            NACK,
    output logic            BUSY
);
    typedef struct packed {
        logic [1:0]    scl_sy;
        logic [1:0]    sda_sy;
        ccs_ms_state_t st;
        ccs_phase_t    ph;
        logic [1:0]    q;
        logic [7:0]    div;
        logic [3:0]    bits;
        logic [7:0]    sh;
        logic          rw;
        logic          sel;
        logic          ptr_en;
        logic [7:0]    ptr;
        logic [7:0]    len;
        logic          scl_oe;
        logic          sda_oe;
        logic          acked;
        logic [7:0]    rdata;
        logic          rvalid;
        logic          done;
        logic          nack;
        logic [23:0]   hold;
    } ccs_ms_regs_t;

    localparam ccs_ms_regs_t MS_RST = '0;
    localparam logic [7:0]   Q_LAST = 8'(QUARTER_CYC - 1);
    localparam logic [23:0]  H_LIM  = 24'(HOLD_CYC);

    ccs_ms_regs_t m_r;
    ccs_ms_regs_t m_nxt;
    logic         f_valid;
    logic [7:0]   f_data;
    logic         tick;
    logic         tx;

    ccs_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (REF_CLK),
        .rst       (RST),
        .ce        (CE),
        .in_valid  (WR_VALID),
        .in_ready  (WR_READY),
        .in_data   (WR_DATA),
        .out_valid (f_valid),
        .out_ready (m_r.st == MS_LOAD),
        .out_data  (f_data)
    );

    // bus idle: both lines seen high
    assign CMD_READY = (m_r.st == MS_IDLE) & m_r.scl_sy[1] & m_r.sda_sy[1];

    always_comb begin
        m_nxt = m_r;
        m_nxt.rvalid = 1'b0;
        m_nxt.done = 1'b0;
        m_nxt.scl_sy = {m_r.scl_sy[0], BUS.scl};
        m_nxt.sda_sy = {m_r.sda_sy[0], BUS.sda};
        tick = (m_r.div == Q_LAST);
        tx = (m_r.ph != PH_DATA) | ~m_r.rw;
        if (m_r.st != MS_IDLE && m_r.st != MS_LOAD) begin
            m_nxt.div = tick ? 8'h00 : m_r.div + 8'h01;
            if (tick) begin
                m_nxt.q = m_r.q + 2'h1;
            end
        end
        case (m_r.st)
            MS_IDLE: begin
                if (CMD_VALID && CMD_READY) begin
                    m_nxt.rw = CMD_RW;
                    m_nxt.sel = CMD_SEL;
                    m_nxt.ptr_en = CMD_PTR_EN;
                    m_nxt.ptr = CMD_PTR;
                    m_nxt.len = CMD_LEN;
                    m_nxt.nack = 1'b0;
                    m_nxt.ph = PH_ADDR;
                    m_nxt.sh = {ADDR_UPPER, CMD_SEL, CMD_RW & ~CMD_PTR_EN};
                    m_nxt.q = '0;
                    m_nxt.div = '0;
                    m_nxt.st = MS_START;
                end
            end
            MS_START: begin
                if (tick) begin
                    case (m_r.q)
                        2'h0: m_nxt.sda_oe = 1'b0;
                        2'h1: m_nxt.scl_oe = 1'b0;
                        2'h2: m_nxt.sda_oe = 1'b1;
                        default: begin
                            m_nxt.scl_oe = 1'b1;
                            m_nxt.bits = '0;
                            m_nxt.st = MS_FRAME;
                        end
                    endcase
                end
            end
            MS_LOAD: begin
                // scl held low while waiting for write data
                if (f_valid) begin
                    m_nxt.sh = f_data;
                    m_nxt.hold = '0;
                    m_nxt.st = MS_FRAME;
                end else if (m_r.hold == H_LIM) begin
                    m_nxt.hold = '0;
                    m_nxt.nack = 1'b1;
                    m_nxt.st = MS_STOP;
                end else begin
                    m_nxt.hold = m_r.hold + 24'h1;
                end
            end
            MS_FRAME: begin
                if (tick) begin
                    case (m_r.q)
                        2'h0: begin
                            if (m_r.bits != BYTE_BITS) begin
                                m_nxt.sda_oe = tx & ~m_r.sh[7];
                            end else begin
                                m_nxt.sda_oe = ~tx & (m_r.len != 8'h01);
                            end
                        end
                        2'h1: m_nxt.scl_oe = 1'b0;
                        2'h2: begin
                            if (m_r.bits != BYTE_BITS) begin
                                m_nxt.sh = {m_r.sh[6:0], m_r.sda_sy[1]};
                            end else begin
                                m_nxt.acked = ~m_r.sda_sy[1];
                            end
                        end
                        default: begin
                            m_nxt.scl_oe = 1'b1;
                            m_nxt.bits = m_r.bits + 4'h1;
                            if (m_r.bits == BYTE_BITS) begin
                                m_nxt.bits = '0;
                                if (tx && !m_r.acked) begin
                                    m_nxt.nack = 1'b1;
                                    m_nxt.st = MS_STOP;
                                end else if (m_r.ph == PH_ADDR && m_r.ptr_en) begin
                                    m_nxt.ph = PH_PTR;
                                    m_nxt.sh = m_r.ptr;
                                end else if (m_r.ph == PH_PTR && m_r.rw) begin
                                    m_nxt.ph = PH_ADDR_R;
                                    m_nxt.sh = {ADDR_UPPER, m_r.sel, 1'b1};
                                    m_nxt.st = MS_START;
                                end else begin
                                    m_nxt.ph = PH_DATA;
                                    if (m_r.ph == PH_DATA) begin
                                        m_nxt.len = m_r.len - 8'h01;
                                        m_nxt.rdata = m_r.sh;
                                        m_nxt.rvalid = m_r.rw;
                                    end
                                    if (m_r.len == 8'h00 ||
                                        (m_r.ph == PH_DATA && m_r.len == 8'h01)) begin
                                        m_nxt.st = MS_STOP;
                                    end else if (!m_r.rw) begin
                                        m_nxt.st = MS_LOAD;
                                    end
                                end
                            end
                        end
                    endcase
                end
            end
            MS_STOP: begin
                if (tick) begin
                    case (m_r.q)
                        2'h0: m_nxt.sda_oe = 1'b1;
                        2'h1: m_nxt.scl_oe = 1'b0;
                        2'h2: m_nxt.sda_oe = 1'b0;
                        default: begin
                            m_nxt.done = 1'b1;
                            m_nxt.st = MS_IDLE;
                        end
                    endcase
                end
            end
            default: begin
                m_nxt.st = MS_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            m_r <= MS_RST;
        end else if (CE) begin
            m_r <= m_nxt;
        end
    end

    assign BUS.scl_out_m = 1'b0;
    assign BUS.scl_oe_m = m_r.scl_oe;
    assign BUS.sda_out_m = 1'b0;
    assign BUS.sda_oe_m = m_r.sda_oe;
    assign RD_VALID = m_r.rvalid;
    assign RD_DATA = m_r.rdata;
    assign DONE = m_r.done;
    assign NACK = m_r.nack;
    assign BUSY = (m_r.st != MS_IDLE);
endmodule

/* File: ccs_pkg.sv */
package ccs_pkg;
    localparam int          CLK_MHZ      = 200;
    localparam int          TIMEOUT_MS   = 35;
    localparam int          HOLD_MAX_MS  = 25;
    localparam int          SCL_KHZ      = 400;
    localparam int          QUARTER_CYC  = CLK_MHZ * 1000 / (SCL_KHZ * 4);
    localparam int          FIFO_DEPTH   = 16;
    localparam int          BYTE_W       = 8;
    localparam logic [5:0]  ADDR_UPPER   = 6'h34;
    localparam logic [3:0]  BYTE_BITS    = 4'h8;
    localparam logic [7:0]  PTR_RESET    = 8'h00;

    typedef enum logic [2:0] {
        SL_IDLE = 3'h0,
        SL_ADDR = 3'h1,
        SL_AACK = 3'h2,
        SL_RX   = 3'h3,
        SL_RACK = 3'h4,
        SL_TX   = 3'h5,
        SL_TACK = 3'h6
    } ccs_sl_state_t;

    typedef enum logic [2:0] {
        MS_IDLE  = 3'h0,
        MS_START = 3'h1,
        MS_FRAME = 3'h2,
        MS_LOAD  = 3'h3,
        MS_STOP  = 3'h4
    } ccs_ms_state_t;

    typedef enum logic [1:0] {
        PH_ADDR   = 2'h0,
        PH_PTR    = 2'h1,
        PH_ADDR_R = 2'h2,
        PH_DATA   = 2'h3
    } ccs_phase_t;
endpackage

/* File: ccs_if.sv */
interface ccs_if;
    logic scl_out_m;
    logic scl_oe_m;
    logic sda_out_m;
    logic sda_oe_m;
    logic sda_out_s;
    logic sda_oe_s;
    logic scl;
    logic sda;

    // pull-ups: a line is low only while someone pulls it
    assign scl = scl_oe_m ? scl_out_m : 1'b1;
    assign sda = (sda_oe_m ? sda_out_m : 1'b1) & (sda_oe_s ? sda_out_s : 1'b1);

    modport host (
        output scl_out_m,
        output scl_oe_m,
        output sda_out_m,
        output sda_oe_m,
        input  scl,
        input  sda
    );

    modport dev (
        output sda_out_s,
        output sda_oe_s,
        input  scl,
        input  sda
    );
endinterface

/* File: ccs_slave.sv */
// Notes on behaviour
// - answer only address 110100 plus select pin
// - eighth bit zero writes, one reads
// - data falling while clock high starts
// - data rising while clock high stops
// - data changes only while clock low
// - ninth clock carries receiver acknowledge
// - acknowledge held low through clock high
// - master nacks last read byte; release
// - all bytes shifted msb first
// - master keeps clock low under 25 ms
// - clock low 35 ms resets port
// - timeout runs only with oscillator running
// - matching address acknowledged both directions
// - first written byte loads the pointer
// - later written bytes stored and acknowledged
// - reads start at current stored pointer
// - repeated start begins new transfer
// - no limit on bytes per transfer
// - works up to 400 kHz clock
// - master starts only on idle bus
// - data only pulled low; clock input only
module ccs_slave
    import ccs_pkg::*;
#(
    parameter int TIMEOUT_CYC = TIMEOUT_MS * CLK_MHZ * 1000
) (
    input  wire logic       REF_CLK,
    input  wire logic       RST,
    input  wire logic       CE,
    input  wire logic       ADDRESS_SELECT_PIN,
    input  wire logic       OSC_RUNNING,
    ccs_if.dev              BUS,
    output logic [7:0]      REG_PTR,
    output logic [7:0]      WR_ADDR,
    output logic [7:0]      WR_DATA,
    output logic            WR_STB,
    output logic            RD_STB,
    input  wire logic [7:0] RD_DATA
);
    typedef struct packed {
        logic [1:0]    scl_sy;
        logic [1:0]    sda_sy;
        logic [1:0]    ad_sy;
        logic [1:0]    osc_sy;
        logic          scl_d;
        logic          sda_d;
        ccs_sl_state_t st;
        logic [3:0]    bits;
        logic [7:0]    sh;
        logic [7:0]    ptr;
        logic [7:0]    waddr;
        logic [7:0]    wdata;
        logic          wstb;
        logic          rstb;
        logic          rw;
        logic          first;
        logic          acked;
        logic          oe;
        logic [23:0]   to_cnt;
    } ccs_sl_regs_t;

    localparam ccs_sl_regs_t SL_RST = '0;
    localparam logic [23:0]  TO_LIM = 24'(TIMEOUT_CYC);

    ccs_sl_regs_t st_r;
    ccs_sl_regs_t st_nxt;
    logic         scl;
    logic         sda;
    logic         rise;
    logic         fall;
    logic         start_c;
    logic         stop_c;
    logic         timed_out;

    always_comb begin
        st_nxt = st_r;
        st_nxt.wstb = 1'b0;
        st_nxt.rstb = 1'b0;
        st_nxt.scl_sy = {st_r.scl_sy[0], BUS.scl};
        st_nxt.sda_sy = {st_r.sda_sy[0], BUS.sda};
        st_nxt.ad_sy = {st_r.ad_sy[0], ADDRESS_SELECT_PIN};
        st_nxt.osc_sy = {st_r.osc_sy[0], OSC_RUNNING};
        st_nxt.scl_d = st_r.scl_sy[1];
        st_nxt.sda_d = st_r.sda_sy[1];
        scl = st_r.scl_sy[1];
        sda = st_r.sda_sy[1];
        // edges sampled at 200 MHz, far above a 400 kHz bus clock
        rise = scl & ~st_r.scl_d;
        fall = ~scl & st_r.scl_d;
        start_c = scl & st_r.scl_d & st_r.sda_d & ~sda;
        stop_c = scl & st_r.scl_d & ~st_r.sda_d & sda;
        timed_out = (st_r.to_cnt == TO_LIM);

        // low-time counter, held at zero while oscillator is off
        if (scl || !st_r.osc_sy[1]) begin
            st_nxt.to_cnt = '0;
        end else if (!timed_out) begin
            st_nxt.to_cnt = st_r.to_cnt + 24'h1;
        end

        case (st_r.st)
            SL_IDLE: begin
                st_nxt.oe = 1'b0;
            end
            SL_ADDR: begin
                if (rise) begin
                    st_nxt.sh = {st_r.sh[6:0], sda};
                    st_nxt.bits = st_r.bits + 4'h1;
                end else if (fall && st_r.bits == BYTE_BITS) begin
                    st_nxt.bits = '0;
                    if (st_r.sh[7:1] == {ADDR_UPPER, st_r.ad_sy[1]}) begin
                        st_nxt.rw = st_r.sh[0];
                        st_nxt.oe = 1'b1;
                        st_nxt.st = SL_AACK;
                    end else begin
                        st_nxt.st = SL_IDLE;
                    end
                end
            end
            SL_AACK: begin
                if (fall) begin
                    if (st_r.rw) begin
                        // first read byte comes from the stored pointer
                        st_nxt.sh = RD_DATA;
                        st_nxt.oe = ~RD_DATA[7];
                        st_nxt.rstb = 1'b1;
                        st_nxt.bits = '0;
                        st_nxt.st = SL_TX;
                    end else begin
                        st_nxt.oe = 1'b0;
                        st_nxt.first = 1'b1;
                        st_nxt.st = SL_RX;
                    end
                end
            end
            SL_RX: begin
                if (rise) begin
                    st_nxt.sh = {st_r.sh[6:0], sda};
                    st_nxt.bits = st_r.bits + 4'h1;
                end else if (fall && st_r.bits == BYTE_BITS) begin
                    st_nxt.bits = '0;
                    st_nxt.oe = 1'b1;
                    st_nxt.st = SL_RACK;
                    if (st_r.first) begin
                        st_nxt.ptr = st_r.sh;
                        st_nxt.first = 1'b0;
                    end else begin
                        st_nxt.waddr = st_r.ptr;
                        st_nxt.wdata = st_r.sh;
                        st_nxt.wstb = 1'b1;
                        st_nxt.ptr = st_r.ptr + 8'h01;
                    end
                end
            end
            SL_RACK: begin
                // ack held until the falling edge ends the ninth clock
                if (fall) begin
                    st_nxt.oe = 1'b0;
                    st_nxt.st = SL_RX;
                end
            end
            SL_TX: begin
                if (rise) begin
                    st_nxt.bits = st_r.bits + 4'h1;
                end else if (fall) begin
                    if (st_r.bits == BYTE_BITS) begin
                        st_nxt.bits = '0;
                        st_nxt.oe = 1'b0;
                        st_nxt.ptr = st_r.ptr + 8'h01;
                        st_nxt.st = SL_TACK;
                    end else begin
                        st_nxt.sh = {st_r.sh[6:0], 1'b0};
                        st_nxt.oe = ~st_r.sh[6];
                    end
                end
            end
            SL_TACK: begin
                if (rise) begin
                    st_nxt.acked = ~sda;
                end else if (fall) begin
                    if (st_r.acked) begin
                        st_nxt.sh = RD_DATA;
                        st_nxt.oe = ~RD_DATA[7];
                        st_nxt.rstb = 1'b1;
                        st_nxt.bits = '0;
                        st_nxt.st = SL_TX;
                    end else begin
                        st_nxt.st = SL_IDLE;
                    end
                end
            end
            default: begin
                st_nxt.st = SL_IDLE;
            end
        endcase

        // bus conditions override whatever the byte engine decided
        if (timed_out) begin
            st_nxt.st = SL_IDLE;
            st_nxt.oe = 1'b0;
        end else if (start_c) begin
            st_nxt.st = SL_ADDR;
            st_nxt.bits = '0;
            st_nxt.oe = 1'b0;
        end else if (stop_c) begin
            st_nxt.st = SL_IDLE;
            st_nxt.oe = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            st_r <= SL_RST;
        end else if (CE) begin
            st_r <= st_nxt;
        end
    end

    assign BUS.sda_out_s = 1'b0;
    assign BUS.sda_oe_s = st_r.oe;
    assign REG_PTR = st_r.ptr;
    assign WR_ADDR = st_r.waddr;
    assign WR_DATA = st_r.wdata;
    assign WR_STB = st_r.wstb;
    assign RD_STB = st_r.rstb;
endmodule

/* File: ccs_checker.sv */
module ccs_checker
    import ccs_pkg::*;
#(
    parameter int TIMEOUT_CYC = 2000
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic sda_out_s,
    input wire logic sda_oe_s,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PERIOD_MIN = 4 * QUARTER_CYC - 4;
    int low_cnt_r;
    int per_cnt_r;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    // cycles of clock low, and cycles since the last clock rise
    always_ff @(posedge REF_CLK) begin
        low_cnt_r <= (RST || scl) ? 0 : low_cnt_r + 1;
        per_cnt_r <= (RST || $rose(scl)) ? 0 : per_cnt_r + 1;
    end

    sequence s_start;
        scl && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $rose(sda);
    endsequence

    a_start_hold: assert property (s_start |-> scl [*8])
        else $error("clock not held high after start");
    a_stop_idle: assert property (s_stop |-> (scl && sda) [*8])
        else $error("bus not idle after stop");
    a_slave_edge: assert property ($changed(sda_oe_s) |-> !scl)
        else $error("slave changed data while clock high");
    a_ack_hold: assert property ($rose(scl) && sda_oe_s |=> sda_oe_s [*8])
        else $error("slave released data during clock high");
    a_addr_quiet: assert property (s_start |=> !sda_oe_s [*8])
        else $error("slave pulled data during address");
    a_timeout_rel: assert property (low_cnt_r > TIMEOUT_CYC + 8 |-> !sda_oe_s)
        else $error("slave holds data after clock timeout");
    a_scl_period: assert property ($rose(scl) |-> per_cnt_r >= PERIOD_MIN)
        else $error("clock period too short");
    a_drain_only: assert property (sda_out_s == 1'b0)
        else $error("slave data output not low");
endmodule

/* File: tb_top.sv */
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ccs_pkg::*;
    localparam int TO_CYC = 2000;
    localparam int WR_N   = 4;
    logic       ref_clk, rst, pin, cmd_valid, cmd_rw, cmd_sel, cmd_pen, wr_valid;
    logic [7:0] cmd_ptr, cmd_len, wr_data, p, q, d;
    logic       cmd_ready, wr_ready, rd_valid, done, nack, busy, wr_stb, rd_stb;
    logic [7:0] rd_data, reg_ptr, wr_addr, s_wr_data;
    logic [7:0] rf [256];
    logic [7:0] em [256];
    logic [7:0] rq [$];
    logic [7:0] rs [$];
    logic [8:0] wb [$];
    logic [8:0] sh;
    logic [3:0] wbit = 4'h0;
    logic       scl_d, sda_d;
    int         error_cnt = 0, tests_run = 0, cyc = 0, seed = 32'h92f5e175;

    ccs_if ccs_if_i ();
    ccs_master #(.HOLD_CYC(3000)) ccs_master_i (.REF_CLK(ref_clk), .RST(rst), .CE(1'b1),
        .BUS(ccs_if_i), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_RW(cmd_rw),
        .CMD_SEL(cmd_sel), .CMD_PTR_EN(cmd_pen), .CMD_PTR(cmd_ptr), .CMD_LEN(cmd_len),
        .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_DATA(wr_data), .RD_VALID(rd_valid),
        .RD_DATA(rd_data), .DONE(done), .NACK(nack), .BUSY(busy));
    ccs_slave #(.TIMEOUT_CYC(TO_CYC)) ccs_slave_i (.REF_CLK(ref_clk), .RST(rst), .CE(1'b1),
        .ADDRESS_SELECT_PIN(pin), .OSC_RUNNING(1'b1), .BUS(ccs_if_i), .REG_PTR(reg_ptr),
        .WR_ADDR(wr_addr), .WR_DATA(s_wr_data), .WR_STB(wr_stb), .RD_STB(rd_stb),
        .RD_DATA(rf[reg_ptr]));
    ccs_checker #(.TIMEOUT_CYC(TO_CYC)) ccs_checker_i (.REF_CLK(ref_clk), .RST(rst),
        .sda_out_s(ccs_if_i.sda_out_s), .sda_oe_s(ccs_if_i.sda_oe_s), .scl(ccs_if_i.scl),
        .sda(ccs_if_i.sda));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // register file, read bytes and bytes seen on the wire with their ninth bit
    always @(negedge ref_clk) begin
        scl_d <= ccs_if_i.scl;
        sda_d <= ccs_if_i.sda;
        if (wr_stb) rf[wr_addr] <= s_wr_data;
        if (rd_valid) rq.push_back(rd_data);
        if (rd_stb) rs.push_back(reg_ptr);
        if (ccs_if_i.scl && scl_d && sda_d && !ccs_if_i.sda) wbit <= 4'h0;
        else if (ccs_if_i.scl && !scl_d) begin
            sh <= {sh[7:0], ccs_if_i.sda};
            wbit <= (wbit == 4'h8) ? 4'h0 : wbit + 4'h1;
            if (wbit == 4'h8) wb.push_back({sh[7:0], ccs_if_i.sda});
        end
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // address byte as seen on the wire, with the acknowledge bit low
    function automatic logic [8:0] addr_byte(input logic sel, input logic rw);
        return {ADDR_UPPER, sel, rw, 1'b0};
    endfunction

    task automatic run(input logic rw, input logic [7:0] ptr, len, input logic pe, sl);
        int n;
        n = 0;
        {cmd_rw, cmd_sel, cmd_pen, cmd_ptr, cmd_len, cmd_valid} <= {rw, sl, pe, ptr, len, 1'b1};
        wb.delete();
        rq.delete();
        rs.delete();
        do @(negedge ref_clk); while (cmd_ready !== 1'b1 && ++n < 9000);
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        do @(negedge ref_clk); while (done !== 1'b1 && ++n < 40000);
        // a transfer that never finishes counts as a mismatch
        if (done !== 1'b1) error_cnt++;
        @(posedge ref_clk);
    endtask

    initial begin
        {rst, pin, cmd_valid, cmd_rw, cmd_sel, cmd_pen, wr_valid} = 7'h40;
        {cmd_ptr, cmd_len, wr_data} = 24'h0;
        for (int i = 0; i < 256; i++) begin
            rf[i] = 8'(i);
            em[i] = 8'(i);
        end
        repeat (20) @(posedge ref_clk);
        p = 8'($random(seed));
        pin <= p[0];
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 16; i++) begin
            d = 8'($random(seed));
            if (i < WR_N) em[p + 8'(i)] = d;
            wr_data <= d;
            wr_valid <= 1'b1;
            @(negedge ref_clk);
            `CHK("wr_ready", 1'b1, wr_ready)
            @(posedge ref_clk);
        end
        wr_valid <= 1'b0;
        @(negedge ref_clk);
        `CHK("wr_full", 1'b0, wr_ready)
        @(posedge ref_clk);
        run(1'b0, p, 8'(WR_N), 1'b1, pin);
        for (int i = 0; i < 16; i++) `CHK("reg_file", em[p + 8'(i)], rf[p + 8'(i)])
        `CHK("reg_ptr", p + 8'(WR_N), reg_ptr)
        `CHK("addr_w", addr_byte(pin, 1'b0), wb[0])
        `CHK("ptr_byte", {p, 1'b0}, wb[1])
        `CHK("nack", 1'b0, nack)
        `CHK("busy", 1'b0, busy)
        $display("test write burst done");
        // reset in mid-run clears the pointer and the unsent fifo words
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        `CHK("ptr_reset", PTR_RESET, reg_ptr)
        `CHK("fifo_clear", 1'b1, wr_ready)
        @(posedge ref_clk);
        $display("test reset done");
        run(1'b1, p, 8'h02, 1'b1, pin);
        `CHK("rd0", em[p], rq[0])
        `CHK("rd1", em[p + 8'h1], rq[1])
        `CHK("rd_strobes", 2, rs.size())
        `CHK("addr_r", addr_byte(pin, 1'b1), wb[2])
        `CHK("wire_d0", {em[p], 1'b0}, wb[3])
        `CHK("last_nack", 1'b1, wb[4][0])
        `CHK("reg_ptr", p + 8'h2, reg_ptr)
        $display("test pointer read done");
        q = 8'($random(seed));
        run(1'b0, q, 8'h01, 1'b1, pin);
        `CHK("starve_nack", 1'b1, nack)
        `CHK("ptr_load", q, reg_ptr)
        $display("test starved write done");
        run(1'b1, 8'h00, 8'h01, 1'b0, pin);
        `CHK("rd_keep", em[q], rq[0])
        `CHK("rd_at", q, rs[0])
        `CHK("reg_ptr", q + 8'h1, reg_ptr)
        $display("test current read done");
        run(1'b0, 8'h00, 8'h01, 1'b1, ~pin);
        `CHK("miss_nack", 1'b1, nack)
        `CHK("miss_ack", 1'b1, wb[0][0])
        `CHK("reg_ptr", q + 8'h1, reg_ptr)
        $display("test wrong address done");
        end_of_test();
    end
endmodule
